// >>> rtl/ecph_map.vh
`ifndef ECPH_MAP_VH
`define ECPH_MAP_VH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define ECPH_CMD_STATUS 8'h50
`define ECPH_CMD_RESET 8'h53
`define ECPH_CMD_SERIAL 8'h56
`define ECPH_CMD_FREE 8'h4E
`define ECPH_CMD_FSTAT 8'h4C
`define ECPH_CMD_CREATE 8'h4D
`define ECPH_CMD_STORE 8'h4B
`define ECPH_CMD_CHCODE 8'h4F
`define ECPH_CMD_ADDR 8'h55
`define ECPH_CMD_IFCFG 8'h57

// ----------------------------------------------------------------------------
// Expected frame lengths in bytes, command byte included
// ----------------------------------------------------------------------------
`define ECPH_LEN_PLAIN 3'h1
`define ECPH_LEN_ONE 3'h2
`define ECPH_LEN_TWO 3'h3
`define ECPH_LEN_THREE 3'h4

// ----------------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------------
`define ECPH_ST_OK 8'h00
`define ECPH_ST_OFFSET 8'h02
`define ECPH_ST_TABLE 8'h03
`define ECPH_ST_I2C 8'h05
`define ECPH_ST_WDT 8'h07
`define ECPH_ST_PARITY 8'h09
`define ECPH_ST_CSUM 8'h0A
`define ECPH_ST_UNKNOWN 8'h0B
`define ECPH_ST_LENGTH 8'h0C
`define ECPH_ST_ARG 8'h0D
`define ECPH_ST_WPROT 8'h0E
`define ECPH_ST_CODE 8'h0F
`define ECPH_ST_FIXED 8'h10
`define ECPH_ST_WADDR 8'h11
`define ECPH_ST_NOFIELD 8'h12
`define ECPH_ST_ANALOG 8'h1C
`define ECPH_ST_TXCUR 8'h1D
`define ECPH_ST_SPEED 8'h1F

// ----------------------------------------------------------------------------
// Reset values, reply error flag and field layout
// ----------------------------------------------------------------------------
`define ECPH_CODE_RST 8'h55
`define ECPH_ADDR_RST 8'h40
`define ECPH_MODE_RST 8'hE4
`define ECPH_FREE_WORDS_RST 16'h0380
`define ECPH_ERR_FLAG 8'h80
`define ECPH_ENT_EXISTS 7
`define ECPH_ENT_PROT 6
`define ECPH_ENT_FIXED 5

`endif

// >>> rtl/ecph_field_ram.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Field table memory with registered read data
// ----------------------------------------------------------------------------
module ecph_field_ram #(
   parameter AW = 3,
   parameter DW = 8
) (
   input wire clk_sys,
   input wire resetn,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata <= {DW{1'b0}};
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule // ecph_field_ram

// >>> rtl/ecph_cmd_handler.v
`timescale 1ns/1ps
`include "ecph_map.vh"

module ecph_cmd_handler #(
   parameter NUM_FIELDS = 8,
   parameter FIELD_AW = 3,
   parameter [15:0] FREE_WORDS = `ECPH_FREE_WORDS_RST,
   parameter [31:0] SERIAL_NUM = 32'h12345678,
   parameter [15:0] PROG_VERSION = 16'h0100
) (
   input wire clk_sys,
   input wire resetn,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_last,
   input wire rx_parity_err,
   input wire rx_csum_err,
   input wire tx_ready,
   input wire boot_wdt_cause,
   input wire boot_table_bad,
   input wire boot_i2c_fail,
   input wire boot_offset_bad,
   input wire mon_overspeed,
   input wire mon_analog_range,
   input wire mon_tx_current,
   output reg tx_valid_r,
   output reg [7:0] tx_data_r,
   output reg busy_r,
   output reg [7:0] enc_addr_r,
   output reg [7:0] if_mode_r,
   output reg [7:0] status_r
);

   // -------------------------------------------------------------------------
   // States and local constants
   // -------------------------------------------------------------------------
   localparam [2:0] S_INIT = 3'h0;
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_LOOK = 3'h2;
   localparam [2:0] S_EVAL = 3'h3;
   localparam [2:0] S_TX = 3'h4;
   localparam integer LAST_I = NUM_FIELDS - 1;
   localparam [7:0] NF8 = NUM_FIELDS[7:0];
   localparam [FIELD_AW-1:0] LAST_IDX = LAST_I[FIELD_AW-1:0];

   // Expected frame length per command; zero marks an unknown command.
   function [2:0] exp_len;
      input [7:0] c;
      begin
         case (c)
            `ECPH_CMD_STATUS, `ECPH_CMD_RESET, `ECPH_CMD_SERIAL,
            `ECPH_CMD_FREE: exp_len = `ECPH_LEN_PLAIN;
            `ECPH_CMD_FSTAT: exp_len = `ECPH_LEN_ONE;
            `ECPH_CMD_CHCODE, `ECPH_CMD_ADDR,
            `ECPH_CMD_IFCFG: exp_len = `ECPH_LEN_TWO;
            `ECPH_CMD_CREATE, `ECPH_CMD_STORE: exp_len = `ECPH_LEN_THREE;
            default: exp_len = 3'h0;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [2:0] state_r;
   reg [FIELD_AW-1:0] init_idx_r;
   reg [7:0] cmd_r;
   reg [7:0] arg1_r;
   reg [7:0] arg2_r;
   reg [7:0] arg3_r;
   reg [2:0] cnt_r;
   reg perr_r;
   reg cerr_r;
   reg [7:0] code_r;
   reg [15:0] free_r;
   reg [7:0] txb_r [0:6];
   reg [2:0] tx_len_r;
   reg [2:0] tx_idx_r;
   reg speed_q_r;
   reg analog_q_r;
   reg txcur_q_r;
   reg [7:0] ev_code;
   reg [15:0] avail;
   integer i;

   wire [7:0] ent;
   wire fld_ok = (arg1_r < NF8);
   wire exists = fld_ok & ent[`ECPH_ENT_EXISTS];
   wire [7:0] ent_size = {3'h0, ent[4:0]};
   wire [7:0] new_size = {3'h0, arg2_r[4:0]};
   wire ram_we;
   wire [FIELD_AW-1:0] ram_waddr;
   wire [7:0] ram_wdata;

   // -------------------------------------------------------------------------
   // Field table
   // -------------------------------------------------------------------------
   assign ram_we = (state_r == S_INIT) ||
                   (state_r == S_EVAL && cmd_r == `ECPH_CMD_CREATE && ev_code == `ECPH_ST_OK);
   assign ram_waddr = (state_r == S_INIT) ? init_idx_r : arg1_r[FIELD_AW-1:0];
   assign ram_wdata = (state_r == S_INIT) ? 8'h00 :
                      {1'b1, arg2_r[7], arg2_r[6], arg2_r[4:0]};

   ecph_field_ram #(
      .AW(FIELD_AW),
      .DW(8)
   ) u_ram (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr(arg1_r[FIELD_AW-1:0]),
      .rdata(ent)
   );

   // -------------------------------------------------------------------------
   // Command evaluation
   // -------------------------------------------------------------------------
   always @* begin
      avail = free_r + (exists ? {8'h00, ent_size} : 16'h0000);
      ev_code = `ECPH_ST_OK;
      if (perr_r) begin
         ev_code = `ECPH_ST_PARITY;
      end else if (cerr_r) begin
         ev_code = `ECPH_ST_CSUM;
      end else if (exp_len(cmd_r) == 3'h0) begin
         ev_code = `ECPH_ST_UNKNOWN;
      end else if (cnt_r != exp_len(cmd_r)) begin
         ev_code = `ECPH_ST_LENGTH;
      end else begin
         case (cmd_r)
            `ECPH_CMD_FSTAT: begin
               if (!exists) ev_code = `ECPH_ST_NOFIELD;
            end
            `ECPH_CMD_STORE: begin
               if (!exists) ev_code = `ECPH_ST_NOFIELD;
               else if (ent[`ECPH_ENT_PROT]) ev_code = `ECPH_ST_WPROT;
               else if (arg2_r >= ent_size) ev_code = `ECPH_ST_WADDR;
            end
            `ECPH_CMD_CREATE: begin
               if (!fld_ok) ev_code = `ECPH_ST_ARG;
               else if (arg3_r != code_r) ev_code = `ECPH_ST_CODE;
               else if (exists && ent[`ECPH_ENT_FIXED]) ev_code = `ECPH_ST_FIXED;
               else if ({8'h00, new_size} > avail) ev_code = `ECPH_ST_ARG;
            end
            `ECPH_CMD_CHCODE, `ECPH_CMD_ADDR, `ECPH_CMD_IFCFG: begin
               if (arg1_r != code_r) ev_code = `ECPH_ST_CODE;
            end
            default: ev_code = `ECPH_ST_OK;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Sequencer, reply and status
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_INIT;
         init_idx_r <= {FIELD_AW{1'b0}};
         cmd_r <= 8'h00;
         arg1_r <= 8'h00;
         arg2_r <= 8'h00;
         arg3_r <= 8'h00;
         cnt_r <= 3'h0;
         perr_r <= 1'b0;
         cerr_r <= 1'b0;
         code_r <= `ECPH_CODE_RST;
         free_r <= FREE_WORDS;
         enc_addr_r <= `ECPH_ADDR_RST;
         if_mode_r <= `ECPH_MODE_RST;
         status_r <= `ECPH_ST_OK;
         for (i = 0; i < 7; i = i + 1) begin
            txb_r[i] <= 8'h00;
         end
         tx_len_r <= 3'h0;
         tx_idx_r <= 3'h0;
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
         busy_r <= 1'b1;
         speed_q_r <= 1'b0;
         analog_q_r <= 1'b0;
         txcur_q_r <= 1'b0;
      end else begin
         speed_q_r <= mon_overspeed;
         analog_q_r <= mon_analog_range;
         txcur_q_r <= mon_tx_current;
         case (state_r)
            S_INIT: begin
               init_idx_r <= init_idx_r + 1'b1;
               if (init_idx_r == LAST_IDX) begin
                  state_r <= S_IDLE;
                  busy_r <= 1'b0;
                  if (boot_wdt_cause) status_r <= `ECPH_ST_WDT;
                  else if (boot_table_bad) status_r <= `ECPH_ST_TABLE;
                  else if (boot_i2c_fail) status_r <= `ECPH_ST_I2C;
                  else if (boot_offset_bad) status_r <= `ECPH_ST_OFFSET;
               end
            end
            S_IDLE: begin
               if (rx_valid) begin
                  case (cnt_r)
                     3'h0: cmd_r <= rx_data;
                     3'h1: arg1_r <= rx_data;
                     3'h2: arg2_r <= rx_data;
                     3'h3: arg3_r <= rx_data;
                     default: cmd_r <= cmd_r;
                  endcase
                  if (cnt_r != 3'h7) cnt_r <= cnt_r + 1'b1;
                  if (rx_parity_err) perr_r <= 1'b1;
                  if (rx_last) begin
                     cerr_r <= rx_csum_err;
                     state_r <= S_LOOK;
                     busy_r <= 1'b1;
                  end
               end
            end
            S_LOOK: begin
               state_r <= S_EVAL;
            end
            S_EVAL: begin
               state_r <= S_TX;
               tx_idx_r <= 3'h0;
               tx_valid_r <= 1'b1;
               cnt_r <= 3'h0;
               perr_r <= 1'b0;
               cerr_r <= 1'b0;
               txb_r[0] <= cmd_r;
               tx_data_r <= cmd_r;
               tx_len_r <= 3'h1;
               if (ev_code != `ECPH_ST_OK) begin
                  // Nothing but the error reply and the status change here.
                  status_r <= ev_code;
                  txb_r[0] <= cmd_r | `ECPH_ERR_FLAG;
                  tx_data_r <= cmd_r | `ECPH_ERR_FLAG;
                  txb_r[1] <= ev_code;
                  tx_len_r <= 3'h2;
               end else begin
                  case (cmd_r)
                     `ECPH_CMD_SERIAL: begin
                        txb_r[1] <= SERIAL_NUM[31:24];
                        txb_r[2] <= SERIAL_NUM[23:16];
                        txb_r[3] <= SERIAL_NUM[15:8];
                        txb_r[4] <= SERIAL_NUM[7:0];
                        txb_r[5] <= PROG_VERSION[15:8];
                        txb_r[6] <= PROG_VERSION[7:0];
                        tx_len_r <= 3'h7;
                     end
                     `ECPH_CMD_FREE: begin
                        txb_r[1] <= free_r[15:8];
                        txb_r[2] <= free_r[7:0];
                        tx_len_r <= 3'h3;
                     end
                     `ECPH_CMD_FSTAT: begin
                        txb_r[1] <= ent;
                        tx_len_r <= 3'h2;
                     end
                     `ECPH_CMD_STATUS: begin
                        txb_r[1] <= status_r;
                        tx_len_r <= 3'h2;
                     end
                     `ECPH_CMD_RESET: status_r <= `ECPH_ST_OK;
                     `ECPH_CMD_CREATE: free_r <= avail - {8'h00, new_size};
                     `ECPH_CMD_CHCODE: code_r <= arg2_r;
                     `ECPH_CMD_ADDR: enc_addr_r <= arg2_r;
                     `ECPH_CMD_IFCFG: if_mode_r <= arg2_r;
                     default: tx_len_r <= 3'h1;
                  endcase
               end
            end
            S_TX: begin
               if (tx_ready) begin
                  if (tx_idx_r == tx_len_r - 1'b1) begin
                     tx_valid_r <= 1'b0;
                     state_r <= S_IDLE;
                     busy_r <= 1'b0;
                  end else begin
                     tx_idx_r <= tx_idx_r + 1'b1;
                     tx_data_r <= txb_r[tx_idx_r + 1'b1];
                  end
               end
            end
            default: begin
               state_r <= S_IDLE;
               busy_r <= 1'b0;
            end
         endcase
         // Monitor events come last so a new fault beats a clear.
         if (mon_overspeed && !speed_q_r) status_r <= `ECPH_ST_SPEED;
         else if (mon_analog_range && !analog_q_r) status_r <= `ECPH_ST_ANALOG;
         else if (mon_tx_current && !txcur_q_r) status_r <= `ECPH_ST_TXCUR;
      end
   end

endmodule // ecph_cmd_handler

// >>> verification/ecph_checker.sv
`timescale 1ns/1ps
module ecph_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_parity_err,
   input wire logic rx_csum_err,
   input wire logic tx_ready,
   input wire logic mon_overspeed,
   input wire logic mon_analog_range,
   input wire logic mon_tx_current,
   input wire logic tx_valid_r,
   input wire logic [7:0] tx_data_r,
   input wire logic busy_r,
   input wire logic [7:0] status_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic first_r;
   logic one_ok;
   // A clean single-byte frame: its first byte is also its last byte.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         first_r <= 1'h1;
      else if (rx_valid && !busy_r)
         first_r <= rx_last;
   end
   assign one_ok = rx_valid && !busy_r && rx_last && first_r && !rx_parity_err && !rx_csum_err;
   a_serial_reply: assert property (one_ok && rx_data == 8'h56 |-> ##3 tx_valid_r && tx_data_r == 8'h56)
      else $error("serial number reply missing");
   a_free_reply: assert property (one_ok && rx_data == 8'h4E |-> ##3 tx_valid_r && tx_data_r == 8'h4E)
      else $error("free memory reply missing");
   a_unknown_cmd: assert property (one_ok && rx_data == 8'h41 |-> ##3 tx_valid_r && tx_data_r == 8'hC1)
      else $error("unknown command not flagged");
   a_parity_flag: assert property (rx_valid && !busy_r && rx_last && rx_parity_err |-> ##3 tx_valid_r && tx_data_r[7])
      else $error("parity fault not flagged");
   a_reply_holds: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
      else $error("reply byte dropped before acceptance");
   a_idle_quiet: assert property (!busy_r |-> !tx_valid_r)
      else $error("reply shown while idle");
   a_speed_fault: assert property ($rose(mon_overspeed) |-> ##[1:3] status_r == 8'h1F)
      else $error("overspeed status missing");
   a_analog_fault: assert property ($rose(mon_analog_range) && !mon_overspeed |-> ##[1:3] status_r == 8'h1C)
      else $error("analog range status missing");
   a_txcur_fault: assert property ($rose(mon_tx_current) && !mon_overspeed && !mon_analog_range |-> ##[1:3] status_r == 8'h1D)
      else $error("transmitter current status missing");
   c_status_read: cover property (one_ok && rx_data == 8'h50);
   c_stall: cover property (tx_valid_r && !tx_ready);
   c_speed: cover property ($rose(mon_overspeed));
endmodule // ecph_chk

// >>> verification/ecph_host_model.sv
`timescale 1ns/1ps
module ecph_host_model (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic tx_valid_r,
   input wire logic [7:0] tx_data_r,
   output var logic tx_ready
);
   logic [7:0] got[$];
   initial tx_ready = 1'h0;
   // A slow host accepts only every second cycle.
   always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'h1;
   always @(posedge clk_sys) if (tx_valid_r && tx_ready) got.push_back(tx_data_r);
endmodule // ecph_host_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam logic [31:0] SER = 32'hA5C31E07;
   localparam logic [15:0] VER = 16'h0203;
   typedef struct {logic [31:0] f; int fl; logic [55:0] r; int rl;} ecph_row_t;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic rx_valid = 1'h0;
   logic [7:0] rx_data = 8'h00;
   logic rx_last = 1'h0;
   logic rx_parity_err = 1'h0;
   logic rx_csum_err = 1'h0;
   logic [3:0] boot = 4'h0;
   logic [2:0] mon = 3'h0;
   logic slow = 1'h0;
   logic tx_ready, tx_valid_r, busy_r;
   logic [7:0] tx_data_r, enc_addr_r, if_mode_r, status_r;
   int errors = 0;
   int cmp_count = 0;
   int base;
   ecph_row_t rows[23];
   logic [7:0] mexp[3] = '{8'h1F, 8'h1C, 8'h1D};
   logic [3:0] bv[4] = '{4'hC, 4'h4, 4'h2, 4'h1};
   logic [7:0] bexp[4] = '{8'h07, 8'h03, 8'h05, 8'h02};
   always #25 clk_sys = ~clk_sys;
   ecph_cmd_handler #(.SERIAL_NUM(SER), .PROG_VERSION(VER)) DUT (.*,
      .boot_wdt_cause(boot[3]), .boot_table_bad(boot[2]), .boot_i2c_fail(boot[1]),
      .boot_offset_bad(boot[0]), .mon_overspeed(mon[2]), .mon_analog_range(mon[1]),
      .mon_tx_current(mon[0]));
   ecph_host_model hm (.*);
   task automatic final_report;
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic do_reset(input logic [3:0] b);
      boot = b;
      resetn = 1'h0;
      repeat (5) @(negedge clk_sys);
      `CHK("status", 8'h00, status_r)
      `CHK("addr", 8'h40, enc_addr_r)
      `CHK("mode", 8'hE4, if_mode_r)
      resetn = 1'h1;
      repeat (12) @(negedge clk_sys);
   endtask
   task automatic txn(input logic [31:0] f, input int fl, input logic [55:0] r, input int rl,
                      input logic pe, input logic ce);
      int k;
      f = f << (8 * (4 - fl));
      r = r << (8 * (7 - rl));
      base = hm.got.size();
      for (int i = 0; i < fl; i++) begin
         rx_valid = 1'h1;
         rx_data = f[31 - 8 * i -: 8];
         rx_last = (i == fl - 1);
         rx_parity_err = pe;
         rx_csum_err = ce && (i == fl - 1);
         @(negedge clk_sys);
      end
      rx_valid = 1'h0;
      rx_last = 1'h0;
      rx_parity_err = 1'h0;
      rx_csum_err = 1'h0;
      repeat (2) @(negedge clk_sys);
      k = 0;
      while (busy_r !== 1'h0 && k < 100) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK("busy", 1'h0, busy_r)
      `CHK("count", rl, hm.got.size() - base)
      for (int i = 0; i < rl; i++) `CHK("reply", r[55 - 8 * i -: 8], hm.got[base + i])
   endtask
   initial begin
      #250000;
      errors++;
      final_report();
   end
   initial begin
      rows = '{'{32'h50, 1, 56'h5000, 2}, '{32'h56, 1, {8'h56, SER, VER}, 7},
         '{32'h4E, 1, 56'h4E0380, 3}, '{32'h4C00, 2, 56'hCC12, 2},
         '{32'h41, 1, 56'hC10B, 2}, '{32'h4C0000, 3, 56'hCC0C, 2},
         '{32'h4D090255, 4, 56'hCD0D, 2}, '{32'h4D01C455, 4, 56'h4D, 1},
         '{32'h4C01, 2, 56'h4CE4, 2}, '{32'h4E, 1, 56'h4E037C, 3},
         '{32'h4B0100AA, 4, 56'hCB0E, 2}, '{32'h4D01C455, 4, 56'hCD10, 2},
         '{32'h4D020254, 4, 56'hCD0F, 2}, '{32'h4B0200AA, 4, 56'hCB12, 2},
         '{32'h4D020255, 4, 56'h4D, 1}, '{32'h4B0202AA, 4, 56'hCB11, 2},
         '{32'h50, 1, 56'h5011, 2}, '{32'h53, 1, 56'h53, 1}, '{32'h50, 1, 56'h5000, 2},
         '{32'h4F5566, 3, 56'h4F, 1}, '{32'h555531, 3, 56'hD50F, 2},
         '{32'h556631, 3, 56'h55, 1}, '{32'h576681, 3, 56'h57, 1}};
      do_reset(4'h0);
      for (int i = 0; i < 23; i++) begin
         slow = (i % 2 == 1);
         txn(rows[i].f, rows[i].fl, rows[i].r, rows[i].rl, 1'h0, 1'h0);
      end
      `CHK("addr", 8'h31, enc_addr_r)
      `CHK("mode", 8'h81, if_mode_r)
      txn(32'h4B0201AA, 4, 56'h4B, 1, 1'h0, 1'h0);
      txn(32'h4E, 1, 56'hCE09, 2, 1'h1, 1'h0);
      txn(32'h4E, 1, 56'hCE0A, 2, 1'h0, 1'h1);
      txn(32'h4C01, 2, 56'hCC09, 2, 1'h1, 1'h1);
      txn(32'h556632, 3, 56'hD509, 2, 1'h1, 1'h0);
      `CHK("addr", 8'h31, enc_addr_r)
      for (int m = 0; m < 3; m++) begin
         mon = 3'h4 >> m;
         repeat (4) @(negedge clk_sys);
         txn(32'h50, 1, {40'h0, 8'h50, mexp[m]}, 2, 1'h0, 1'h0);
         mon = 3'h0;
      end
      for (int b = 0; b < 4; b++) begin
         do_reset(bv[b]);
         `CHK("boot", bexp[b], status_r)
      end
      final_report();
   end
endmodule // testbench
bind ecph_cmd_handler ecph_chk u_chk (.*);
